//--- rtl/bfe_pkg.sv
/*
  Shared constants and types for the bit-field and flow-control execute unit.
  Assumes a decoder ahead of the unit that maps each instruction onto bfe_op_t.
*/
package bfe_pkg;

  typedef enum {
    OP_NONE,
    OP_SIGNED_FIELD_EXTRACT,
    OP_UNSIGNED_FIELD_EXTRACT,
    OP_SIGN_EXT_BYTE,
    OP_ZERO_EXT_BYTE,
    OP_SIGN_EXT_HALF,
    OP_ZERO_EXT_HALF,
    OP_FIELD_CLEAR,
    OP_FIELD_INSERT,
    OP_BRANCH_IMM,
    OP_CALL_IMMEDIATE,
    OP_JUMP_REGISTER,
    OP_CALL_REGISTER,
    OP_COMPARE_ZERO_JUMP,
    OP_COMPARE_NONZERO_JUMP,
    OP_IF_THEN_BLOCK
  } bfe_op_t;

  localparam int WORD_W = 32;
  localparam int LSB_W = 5;
  localparam int WIDTH_W = 6;
  localparam int ROT_W = 2;
  localparam int COND_W = 4;
  localparam int IT_CNT_W = 3;
  localparam int IT_SW_W = 3;

  localparam logic [COND_W-1:0] COND_EVERY_TIME = 4'he;
  localparam logic [IT_CNT_W-1:0] IT_MAX_LEN = 3'h4;
  localparam int ROT_STEP = 8;
  localparam int NEAR_OFS_MSB = 20;
  localparam int FAR_OFS_MSB = 24;
  localparam int CZ_OFS_MSB = 6;
  localparam logic [WORD_W-1:0] PC_AHEAD = 32'h0000_0004;
  localparam logic [WORD_W-1:0] INSTR_LONG = 32'h0000_0004;
  localparam logic [WORD_W-1:0] INSTR_SHORT = 32'h0000_0002;
  localparam logic [WORD_W-1:0] WORD_RST = 32'h0000_0000;
  localparam logic [WORD_W-1:0] ADDR_BIT0_CLR = 32'hffff_fffe;

endpackage

//--- rtl/bfe_field_unit.sv
/*
  Combinational field datapath: extract, clear, insert and byte/half extension.
  Assumes operands are stable for the cycle; illegal lsb/width give any value.
*/
`timescale 1ns/1ps
module bfe_field_unit
  import bfe_pkg::*;
(
  input bfe_pkg::bfe_op_t op,
  input wire logic [bfe_pkg::WORD_W-1:0] src,
  input wire logic [bfe_pkg::WORD_W-1:0] dst,
  input wire logic [bfe_pkg::LSB_W-1:0] lsb,
  input wire logic [bfe_pkg::WIDTH_W-1:0] width,
  input wire logic [bfe_pkg::ROT_W-1:0] rot,
  output logic [bfe_pkg::WORD_W-1:0] result
);
  import bfe_pkg::*;

  logic [2*WORD_W-1:0] mask_wide;
  logic [WORD_W-1:0] mask;
  logic [WORD_W-1:0] shifted;
  logic [WORD_W-1:0] field;
  logic [WORD_W-1:0] hole;
  logic [2*WORD_W-1:0] rot_wide;
  logic [WORD_W-1:0] rotated;
  logic [WIDTH_W-1:0] top_idx;

  // a 64-bit mask keeps width 32 from wrapping to zero
  assign mask_wide = (64'h0000_0000_0000_0001 << width) - 64'h0000_0000_0000_0001;
  assign mask = mask_wide[WORD_W-1:0];
  assign shifted = src >> lsb;
  assign field = shifted & mask;
  assign hole = ~(mask << lsb);
  assign top_idx = width - 6'h01;
  assign rot_wide = {src, src} >> (rot * ROT_STEP);
  assign rotated = rot_wide[WORD_W-1:0];

  always_comb
  begin
    result = dst;
    case (op)
      OP_SIGNED_FIELD_EXTRACT:
        result = shifted[top_idx[LSB_W-1:0]] ? (field | ~mask) : field;
      OP_UNSIGNED_FIELD_EXTRACT:
        result = field;
      OP_SIGN_EXT_BYTE:
        result = {{24{rotated[7]}}, rotated[7:0]};
      OP_ZERO_EXT_BYTE:
        result = {24'h00_0000, rotated[7:0]};
      OP_SIGN_EXT_HALF:
        result = {{16{rotated[15]}}, rotated[15:0]};
      OP_ZERO_EXT_HALF:
        result = {16'h0000, rotated[15:0]};
      OP_FIELD_CLEAR:
        result = dst & hole;
      OP_FIELD_INSERT:
        result = (dst & hole) | ((src & mask) << lsb);
      default:
        result = dst;
    endcase
  end
endmodule

//--- rtl/bfe_it_tracker.sv
/*
  If-then block state: base condition, remaining length and pending switches.
  Assumes the caller loads only outside a block and steps once per instruction.
*/
`timescale 1ns/1ps
module bfe_it_tracker
  import bfe_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic load,
  input wire logic [bfe_pkg::COND_W-1:0] load_cond,
  input wire logic [bfe_pkg::IT_CNT_W-1:0] load_len,
  input wire logic [bfe_pkg::IT_SW_W-1:0] load_else,
  input wire logic step,
  output logic active,
  output logic [bfe_pkg::COND_W-1:0] cur_cond,
  output logic last
);
  import bfe_pkg::*;

  logic [IT_CNT_W-1:0] cnt_r;
  logic [COND_W-1:0] cond_r;
  logic [IT_SW_W-1:0] else_r;
  logic inv_r;
  logic [IT_CNT_W-1:0] len_nxt;

  // out-of-range lengths are clamped rather than trapped
  assign len_nxt = (load_len > IT_MAX_LEN) ? IT_MAX_LEN :
                   (load_len == 3'h0) ? 3'h1 : load_len;

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      cnt_r <= 3'h0;
      cond_r <= 4'h0;
      else_r <= 3'h0;
      inv_r <= 1'b0;
    end
    else if (load)
    begin
      cnt_r <= len_nxt;
      cond_r <= load_cond;
      else_r <= load_else;
      inv_r <= 1'b0;
    end
    else if (step && cnt_r != 3'h0)
    begin
      cnt_r <= cnt_r - 3'h1;
      inv_r <= else_r[0];
      else_r <= {1'b0, else_r[IT_SW_W-1:1]};
    end
  end

  assign active = (cnt_r != 3'h0);
  assign last = (cnt_r == 3'h1);
  // an else slot flips the low condition bit, giving the inverse test
  assign cur_cond = {cond_r[COND_W-1:1], cond_r[0] ^ inv_r};
endmodule

//--- rtl/bfe_exec.sv
/*
  Execute stage for bit-field, extension and flow-control operations.
  Assumes an external evaluator answers cond_met for cond_sel in the same cycle
  and a decoder supplies operands, immediate and block fields already split out.
*/
`timescale 1ns/1ps
module bfe_exec
  import bfe_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic in_valid,
  input bfe_pkg::bfe_op_t in_op,
  input wire logic [bfe_pkg::COND_W-1:0] in_cond,
  input wire logic in_len4,
  input wire logic [bfe_pkg::WORD_W-1:0] in_pc,
  input wire logic [bfe_pkg::WORD_W-1:0] in_src,
  input wire logic [bfe_pkg::WORD_W-1:0] in_dst,
  input wire logic [bfe_pkg::WORD_W-1:0] in_imm,
  input wire logic [bfe_pkg::LSB_W-1:0] in_lsb,
  input wire logic [bfe_pkg::WIDTH_W-1:0] in_width,
  input wire logic [bfe_pkg::ROT_W-1:0] in_rot,
  input wire logic [bfe_pkg::IT_CNT_W-1:0] in_it_len,
  input wire logic [bfe_pkg::IT_SW_W-1:0] in_it_else,
  input wire logic cond_met,
  output logic [bfe_pkg::COND_W-1:0] cond_sel,
  output logic it_active,
  output logic done,
  output logic res_we,
  output logic [bfe_pkg::WORD_W-1:0] res_data,
  output logic ret_we,
  output logic [bfe_pkg::WORD_W-1:0] ret_data,
  output logic flow_taken,
  output logic [bfe_pkg::WORD_W-1:0] flow_target,
  output logic misuse_fault,
  output logic flags_we
);
  import bfe_pkg::*;

  logic it_last;
  logic [COND_W-1:0] it_cond;
  logic it_load;
  logic it_step;
  logic exec_ok;
  logic is_field;
  logic is_reg_jump;
  logic is_cz;
  logic [WORD_W-1:0] field_res;
  logic [WORD_W-1:0] ofs;
  logic [WORD_W-1:0] ret_nxt;
  logic taken_nxt;
  logic [WORD_W-1:0] target_nxt;
  logic fault_nxt;
  logic done_r;
  logic res_we_r;
  logic [WORD_W-1:0] res_data_r;
  logic ret_we_r;
  logic [WORD_W-1:0] ret_data_r;
  logic taken_r;
  logic [WORD_W-1:0] target_r;
  logic fault_r;

  bfe_field_unit u_field (
    .op(in_op),
    .src(in_src),
    .dst(in_dst),
    .lsb(in_lsb),
    .width(in_width),
    .rot(in_rot),
    .result(field_res)
  );

  // a block opener inside a block is dropped, not nested
  assign it_load = in_valid && in_op == OP_IF_THEN_BLOCK && !it_active;
  assign it_step = in_valid && it_active && in_op != OP_IF_THEN_BLOCK;

  bfe_it_tracker u_it (
    .ref_clk(ref_clk),
    .srst(srst),
    .load(it_load),
    .load_cond(in_cond),
    .load_len(in_it_len),
    .load_else(in_it_else),
    .step(it_step),
    .active(it_active),
    .cur_cond(it_cond),
    .last(it_last)
  );

  // inside a block the slot condition rules; outside only the immediate branch is tested
  assign cond_sel = it_active ? it_cond : in_cond;
  assign exec_ok = it_active ? cond_met :
                   (in_op == OP_BRANCH_IMM) ? cond_met : 1'b1;

  assign is_field = in_op inside {OP_SIGNED_FIELD_EXTRACT, OP_UNSIGNED_FIELD_EXTRACT,
                                  OP_SIGN_EXT_BYTE, OP_ZERO_EXT_BYTE, OP_SIGN_EXT_HALF,
                                  OP_ZERO_EXT_HALF, OP_FIELD_CLEAR, OP_FIELD_INSERT};
  assign is_reg_jump = in_op == OP_JUMP_REGISTER || in_op == OP_CALL_REGISTER;
  assign is_cz = in_op == OP_COMPARE_ZERO_JUMP || in_op == OP_COMPARE_NONZERO_JUMP;
  assign ret_nxt = in_pc + (in_len4 ? INSTR_LONG : INSTR_SHORT);

  always_comb
  begin
    ofs = WORD_RST;
    taken_nxt = 1'b0;
    target_nxt = target_r;
    fault_nxt = 1'b0;
    if (in_valid && exec_ok)
    begin
      case (in_op)
        OP_BRANCH_IMM, OP_CALL_IMMEDIATE:
        begin
          // short reach only for a conditional branch outside a block
          if (!it_active && in_op == OP_BRANCH_IMM && in_cond != COND_EVERY_TIME)
            ofs = {{11{in_imm[NEAR_OFS_MSB]}}, in_imm[NEAR_OFS_MSB:1], 1'b0};
          else
            ofs = {{7{in_imm[FAR_OFS_MSB]}}, in_imm[FAR_OFS_MSB:1], 1'b0};
          taken_nxt = 1'b1;
          target_nxt = in_pc + PC_AHEAD + ofs;
        end
        OP_JUMP_REGISTER, OP_CALL_REGISTER:
        begin
          fault_nxt = !in_src[0];
          taken_nxt = in_src[0];
          target_nxt = in_src & ADDR_BIT0_CLR;
        end
        OP_COMPARE_ZERO_JUMP, OP_COMPARE_NONZERO_JUMP:
        begin
          // unsigned offset keeps the target 4..130 bytes ahead
          ofs = {{25{1'b0}}, in_imm[CZ_OFS_MSB:1], 1'b0};
          taken_nxt = (in_src == WORD_RST) == (in_op == OP_COMPARE_ZERO_JUMP);
          target_nxt = in_pc + PC_AHEAD + ofs;
        end
        default:
          taken_nxt = 1'b0;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      done_r <= 1'b0;
    else
      done_r <= in_valid;
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      res_we_r <= 1'b0;
      res_data_r <= WORD_RST;
    end
    else
    begin
      res_we_r <= in_valid && exec_ok && is_field;
      // a suppressed slot leaves the held result alone
      if (in_valid && exec_ok && is_field)
        res_data_r <= field_res;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      ret_we_r <= 1'b0;
      ret_data_r <= WORD_RST;
    end
    else
    begin
      // a faulting register call still loads ret_data with the return address but holds ret_we low
      ret_we_r <= in_valid && exec_ok && (in_op == OP_CALL_IMMEDIATE ||
                  (in_op == OP_CALL_REGISTER && in_src[0]));
      if (in_valid && exec_ok && (in_op == OP_CALL_IMMEDIATE || in_op == OP_CALL_REGISTER))
        ret_data_r <= ret_nxt;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      taken_r <= 1'b0;
      target_r <= WORD_RST;
      fault_r <= 1'b0;
    end
    else
    begin
      taken_r <= taken_nxt;
      target_r <= target_nxt;
      fault_r <= fault_nxt;
    end
  end

  assign done = done_r;
  assign res_we = res_we_r;
  assign res_data = res_data_r;
  assign ret_we = ret_we_r;
  assign ret_data = ret_data_r;
  assign flow_taken = taken_r;
  assign flow_target = target_r;
  assign misuse_fault = fault_r;
  assign flags_we = 1'b0;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  a_flags_untouched: assert property (done |-> !flags_we)
    else $error("flags written by bit-field or flow op");

  a_byte_sign_ext: assert property (
    in_valid && !it_active && in_op == OP_SIGN_EXT_BYTE && in_rot == 2'h1
    |=> res_we && res_data == {{24{$past(in_src[15])}}, $past(in_src[15:8])})
    else $error("byte sign extension after rotate by 8 wrong");

  a_half_zero_ext: assert property (
    in_valid && !it_active && in_op == OP_ZERO_EXT_HALF && in_rot == 2'h2
    |=> res_data == {16'h0000, $past(in_src[31:16])})
    else $error("halfword zero extension after rotate by 16 wrong");

  a_ufx_result: assert property (
    in_valid && !it_active && in_op == OP_UNSIGNED_FIELD_EXTRACT
    && in_lsb == 5'h09 && in_width == 6'h0a
    |=> res_data == {22'h00_0000, $past(in_src[18:9])})
    else $error("unsigned extract of 10 bits at 9 wrong");

  a_sfx_result: assert property (
    in_valid && !it_active && in_op == OP_SIGNED_FIELD_EXTRACT
    && in_lsb == 5'h14 && in_width == 6'h04
    |=> res_data == {{28{$past(in_src[23])}}, $past(in_src[23:20])})
    else $error("signed extract of 4 bits at 20 wrong");

  a_call_return: assert property (
    in_valid && !it_active && in_op == OP_CALL_IMMEDIATE
    |=> ret_we && flow_taken
    && ret_data == $past(in_pc) + ($past(in_len4) ? INSTR_LONG : INSTR_SHORT))
    else $error("call did not save next address");

  a_reg_jump_fault: assert property (
    in_valid && !it_active && is_reg_jump && !in_src[0]
    |=> misuse_fault && !flow_taken && !ret_we)
    else $error("misuse fault missing for even register target");

  a_reg_jump_target: assert property (
    in_valid && !it_active && is_reg_jump && in_src[0]
    |=> flow_taken && !misuse_fault && flow_target == {$past(in_src[31:1]), 1'b0})
    else $error("register jump target wrong");

  a_cz_forward: assert property (
    in_valid && !it_active && is_cz
    |=> (flow_taken == (($past(in_src) == WORD_RST) == ($past(in_op) == OP_COMPARE_ZERO_JUMP)))
    && (flow_target - $past(in_pc)) >= 32'h0000_0004
    && (flow_target - $past(in_pc)) <= 32'h0000_0082)
    else $error("compare jump decision or reach wrong");

  a_near_reach: assert property (
    in_valid && !it_active && in_op == OP_BRANCH_IMM && in_cond != COND_EVERY_TIME && cond_met
    |=> flow_taken && $signed(flow_target - $past(in_pc) - PC_AHEAD) < $signed(32'h0010_0000)
    && $signed(flow_target - $past(in_pc) - PC_AHEAD) >= $signed(32'hfff0_0000))
    else $error("conditional branch outside block exceeds 1 MB");

  a_slot_suppress: assert property (
    it_step && !cond_met |=> !res_we && !ret_we && !flow_taken && !misuse_fault)
    else $error("failed slot was not suppressed");

  a_block_length: assert property (
    it_load && in_it_len == 3'h2 ##1 it_step ##1 it_step |=> !it_active)
    else $error("block of two did not close after two steps");

  // slot two is only seen when the block is longer than one
  a_else_inverse: assert property (
    it_load && in_it_else[0] && in_it_len > 3'h1 ##1 it_step
    |=> cond_sel[0] != $past(in_cond[0], 2))
    else $error("else slot did not invert the condition");

  c_block_full: cover property (it_load && in_it_len == 3'h4);
  c_misuse: cover property (misuse_fault);
  c_cz_taken: cover property (flow_taken && $past(is_cz));
  c_suppressed: cover property (it_step && !cond_met);
  c_last_branch: cover property (it_last && in_valid && in_op == OP_BRANCH_IMM);
endmodule

//--- dv/bfe_cond_model.sv
/*
  Condition evaluator standing beside the execute unit, answering cond_met.
  Assumes the bench chooses which even condition codes pass; odd codes invert.
*/
`timescale 1ns/1ps
module bfe_cond_model
  import bfe_pkg::*;
(
  input wire logic [bfe_pkg::COND_W-1:0] cond_sel,
  input wire logic [7:0] pass_even,
  output logic cond_met
);
  // odd codes below 4'hf answer the inverse of their even partner, as real flags do
  always_comb
  begin
    if (cond_sel == COND_EVERY_TIME)
      cond_met = 1'b1;
    else
      cond_met = pass_even[cond_sel[3:1]] ^ cond_sel[0];
  end
endmodule

//--- dv/tb.sv
/*
  Self-checking bench for bfe_exec: table-driven field and flow rows,
  then hand-written if-then block and reset cases.
  Assumes bfe_pkg, the design and the condition model are compiled first.
*/
`timescale 1ns/1ps
module tb;
  import bfe_pkg::*;
  typedef struct {
    bfe_op_t op;
    logic [31:0] src;
    logic [31:0] dst;
    logic [4:0] lsb;
    logic [5:0] width;
    logic [1:0] rot;
    logic [31:0] res;
  } bfe_frow_t;
  typedef struct {
    bfe_op_t op;
    logic [3:0] cond;
    logic len4;
    logic [31:0] src;
    logic [31:0] imm;
    logic taken;
    logic [31:0] tgt;
    logic ret_we;
    logic fault;
  } bfe_brow_t;
  localparam logic [WORD_W-1:0] PC0 = 32'h0000_1000;
  logic ref_clk;
  logic srst;
  logic in_valid;
  bfe_op_t in_op;
  logic [COND_W-1:0] in_cond;
  logic in_len4;
  logic [WORD_W-1:0] in_pc, in_src, in_dst, in_imm;
  logic [LSB_W-1:0] in_lsb;
  logic [WIDTH_W-1:0] in_width;
  logic [ROT_W-1:0] in_rot;
  logic [IT_CNT_W-1:0] in_it_len;
  logic [IT_SW_W-1:0] in_it_else;
  logic cond_met, it_active, done, res_we, ret_we, flow_taken, misuse_fault, flags_we;
  logic [COND_W-1:0] cond_sel;
  logic [WORD_W-1:0] res_data, ret_data, flow_target, ra;
  logic [7:0] pass_even;
  int bad_count = 0;
  int checks_done = 0;
  int cycles = 0;
  // legal positions and widths only
  bfe_frow_t frows[12] = '{
    '{OP_SIGNED_FIELD_EXTRACT, 32'h0080_0000, '0, 5'h14, 6'h04, 2'h0, 32'hffff_fff8},
    '{OP_UNSIGNED_FIELD_EXTRACT, 32'hffff_ffff, '0, 5'h09, 6'h0a, 2'h0, 32'h0000_03ff},
    '{OP_SIGNED_FIELD_EXTRACT, 32'h8000_0001, '0, 5'h00, 6'h20, 2'h0, 32'h8000_0001},
    '{OP_UNSIGNED_FIELD_EXTRACT, 32'h8000_0000, '0, 5'h1f, 6'h01, 2'h0, 32'h0000_0001},
    '{OP_SIGN_EXT_BYTE, 32'h1234_8680, '0, '0, '0, 2'h1, 32'hffff_ff86},
    '{OP_ZERO_EXT_BYTE, 32'h1234_5680, '0, '0, '0, 2'h1, 32'h0000_0056},
    '{OP_SIGN_EXT_HALF, 32'h8765_4321, '0, '0, '0, 2'h2, 32'hffff_8765},
    '{OP_ZERO_EXT_HALF, 32'h8765_4321, '0, '0, '0, 2'h3, 32'h0000_2187},
    '{OP_ZERO_EXT_HALF, 32'h8765_4321, '0, '0, '0, 2'h2, 32'h0000_8765},
    '{OP_FIELD_CLEAR, '0, 32'hffff_ffff, 5'h08, 6'h0c, 2'h0, 32'hfff0_00ff},
    '{OP_FIELD_INSERT, 32'hffff_fabc, '0, 5'h08, 6'h0c, 2'h0, 32'h000a_bc00},
    '{OP_FIELD_INSERT, 32'h0000_0005, 32'h1234_5678, 5'h1c, 6'h04, 2'h0, 32'h5234_5678}};
  // operands stand for low registers; the program counter is never a call operand
  bfe_brow_t brows[12] = '{
    '{OP_CALL_IMMEDIATE, 4'he, 1'b1, '0, 32'h0000_0100, 1'b1, 32'h0000_1104, 1'b1, 1'b0},
    '{OP_CALL_REGISTER, 4'he, 1'b0, 32'h0000_3001, '0, 1'b1, 32'h0000_3000, 1'b1, 1'b0},
    '{OP_CALL_REGISTER, 4'he, 1'b0, 32'h0000_3000, '0, 1'b0, '0, 1'b0, 1'b1},
    '{OP_JUMP_REGISTER, 4'he, 1'b1, 32'h0000_4001, '0, 1'b1, 32'h0000_4000, 1'b0, 1'b0},
    '{OP_BRANCH_IMM, 4'he, 1'b1, '0, 32'hff00_0000, 1'b1, 32'hff00_1004, 1'b0, 1'b0},
    '{OP_BRANCH_IMM, 4'h0, 1'b1, '0, 32'h0010_0000, 1'b1, 32'hfff0_1004, 1'b0, 1'b0},
    '{OP_BRANCH_IMM, 4'h0, 1'b1, '0, 32'h000f_fffe, 1'b1, 32'h0010_1002, 1'b0, 1'b0},
    '{OP_BRANCH_IMM, 4'h1, 1'b1, '0, 32'h0000_0100, 1'b0, '0, 1'b0, 1'b0},
    '{OP_COMPARE_ZERO_JUMP, 4'h1, 1'b0, '0, 32'h0000_007e, 1'b1, 32'h0000_1082, 1'b0, 1'b0},
    '{OP_COMPARE_ZERO_JUMP, 4'h1, 1'b0, 32'h0000_0001, 32'h0000_007e, 1'b0, '0, 1'b0, 1'b0},
    '{OP_COMPARE_NONZERO_JUMP, 4'h1, 1'b0, 32'h8000_0000, '0, 1'b1, 32'h0000_1004, 1'b0, 1'b0},
    '{OP_COMPARE_NONZERO_JUMP, 4'h1, 1'b0, '0, '0, 1'b0, '0, 1'b0, 1'b0}};

  bfe_exec DUT (.ref_clk, .srst, .in_valid, .in_op, .in_cond, .in_len4, .in_pc, .in_src,
    .in_dst, .in_imm, .in_lsb, .in_width, .in_rot, .in_it_len, .in_it_else, .cond_met,
    .cond_sel, .it_active, .done, .res_we, .res_data, .ret_we, .ret_data, .flow_taken,
    .flow_target, .misuse_fault, .flags_we);
  bfe_cond_model u_cond (.cond_sel, .pass_even, .cond_met);

  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task end_sim;
    $display("checks_done %0d bad_count %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // one instruction with idle after it; results are settled at the negedge
  task run(input bfe_op_t op, input logic [3:0] cond, input logic [31:0] src,
    input logic [31:0] imm, input logic [2:0] len = 3'h1, input logic [2:0] els = 3'h0);
    @(posedge ref_clk);
    in_valid <= 1'b1;
    in_op <= op;
    in_cond <= cond;
    in_src <= src;
    in_imm <= imm;
    in_rot <= '0;
    in_it_len <= len;
    in_it_else <= els;
    @(posedge ref_clk);
    in_valid <= 1'b0;
    @(negedge ref_clk);
  endtask

  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 1000)
    begin
      bad_count++;
      $display("test timeout");
      end_sim;
    end
  end

  initial
  begin
    {srst, in_valid, in_len4, in_src, in_dst, in_imm} = {1'b1, 98'h0};
    {in_lsb, in_width, in_rot, in_it_len, in_it_else} = '0;
    in_op = OP_NONE;
    in_cond = 4'h5;
    in_pc = PC0;
    pass_even = 8'h01;
    repeat (12) @(posedge ref_clk);
    srst <= 1'b0;
    @(negedge ref_clk);
    chk("it_active", 1'b0, it_active);
    chk("cond_sel", 4'h5, cond_sel);
    chk("done", 1'b0, done);
    chk("res_data", '0, res_data);
    chk("ret_data", '0, ret_data);
    chk("flow_target", '0, flow_target);
    $display("test reset done");
    // back to back: row i is taken while row i-1 is checked
    for (int i = 0; i <= 12; i++)
    begin
      @(posedge ref_clk);
      in_valid <= (i < 12);
      if (i < 12)
      begin
        in_op <= frows[i].op;
        in_cond <= COND_EVERY_TIME;
        in_src <= frows[i].src;
        in_dst <= frows[i].dst;
        in_lsb <= frows[i].lsb;
        in_width <= frows[i].width;
        in_rot <= frows[i].rot;
      end
      @(negedge ref_clk);
      if (i > 0)
      begin
        chk("res_we", 1'b1, res_we);
        chk("res_data", frows[i-1].res, res_data);
        chk("flags_we", 1'b0, flags_we);
      end
    end
    $display("test field rows done");
    for (int i = 0; i <= 12; i++)
    begin
      @(posedge ref_clk);
      in_valid <= (i < 12);
      if (i < 12)
      begin
        in_op <= brows[i].op;
        in_cond <= brows[i].cond;
        in_len4 <= brows[i].len4;
        in_src <= brows[i].src;
        in_imm <= brows[i].imm;
      end
      @(negedge ref_clk);
      if (i > 0)
      begin
        ra = PC0 + (brows[i-1].len4 ? INSTR_LONG : INSTR_SHORT);
        chk("done", 1'b1, done);
        chk("flow_taken", brows[i-1].taken, flow_taken);
        if (brows[i-1].taken)
          chk("flow_target", brows[i-1].tgt, flow_target);
        chk("ret_we", brows[i-1].ret_we, ret_we);
        if (brows[i-1].ret_we)
          chk("ret_data", ra, ret_data);
        chk("misuse_fault", brows[i-1].fault, misuse_fault);
        chk("flags_we", 1'b0, flags_we);
      end
    end
    $display("test flow rows done");
    // compare jumps kept out of blocks, branch only in last slot
    run(OP_IF_THEN_BLOCK, 4'h0, '0, '0, 3'h4, 3'h2);
    chk("it_active", 1'b1, it_active);
    chk("cond_sel", 4'h0, cond_sel);
    run(OP_ZERO_EXT_BYTE, 4'h0, 32'h0000_01a5, '0);
    chk("res_data", 32'h0000_00a5, res_data);
    chk("cond_sel", 4'h0, cond_sel);
    run(OP_SIGN_EXT_HALF, 4'h0, 32'h0000_8001, '0);
    chk("res_data", 32'hffff_8001, res_data);
    chk("cond_sel", 4'h1, cond_sel);
    run(OP_ZERO_EXT_BYTE, 4'h1, 32'h0000_0033, '0);
    chk("res_we", 1'b0, res_we);
    chk("res_data", 32'hffff_8001, res_data);
    chk("cond_sel", 4'h0, cond_sel);
    run(OP_BRANCH_IMM, 4'h0, '0, 32'h00f0_0000);
    chk("flow_target", 32'h00f0_1004, flow_target);
    chk("it_active", 1'b0, it_active);
    // block of two, opener and both slots back to back, slot two on else
    @(posedge ref_clk);
    in_valid <= 1'b1;
    in_op <= OP_IF_THEN_BLOCK;
    in_cond <= 4'h0;
    in_it_len <= 3'h2;
    in_it_else <= 3'h1;
    @(posedge ref_clk);
    in_op <= OP_ZERO_EXT_BYTE;
    in_src <= 32'h0000_0011;
    @(posedge ref_clk);
    in_src <= 32'h0000_0022;
    @(negedge ref_clk);
    chk("res_data", 32'h0000_0011, res_data);
    chk("cond_sel", 4'h1, cond_sel);
    @(posedge ref_clk);
    in_valid <= 1'b0;
    @(negedge ref_clk);
    chk("res_we", 1'b0, res_we);
    chk("res_data", 32'h0000_0011, res_data);
    chk("it_active", 1'b0, it_active);
    $display("test block slots done");
    // every-time block with no else switch
    run(OP_IF_THEN_BLOCK, COND_EVERY_TIME, '0, '0, 3'h7, 3'h0);
    for (int k = 0; k < 4; k++)
    begin
      if (k == 2)
        run(OP_IF_THEN_BLOCK, 4'h1, '0, '0, 3'h1, 3'h0);
      chk("cond_sel", COND_EVERY_TIME, cond_sel);
      run(OP_ZERO_EXT_HALF, COND_EVERY_TIME, 32'h1234_5678, '0);
      chk("res_data", 32'h0000_5678, res_data);
      chk("it_active", k < 3, it_active);
    end
    run(OP_IF_THEN_BLOCK, 4'h1, '0, '0, 3'h1, 3'h0);
    run(OP_CALL_REGISTER, 4'h1, 32'h0000_3001, '0);
    chk("done", 1'b1, done);
    chk("ret_we", 1'b0, ret_we);
    chk("flow_taken", 1'b0, flow_taken);
    chk("it_active", 1'b0, it_active);
    $display("test block length done");
    run(OP_IF_THEN_BLOCK, 4'h0, '0, '0, 3'h4, 3'h0);
    chk("it_active", 1'b1, it_active);
    @(posedge ref_clk);
    srst <= 1'b1;
    in_cond <= 4'h5;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    @(negedge ref_clk);
    chk("it_active", 1'b0, it_active);
    chk("cond_sel", 4'h5, cond_sel);
    $display("test mid reset done");
    end_sim;
  end
endmodule
